// file: logic/or_move_rotate_execute.sv
// execution of the or, move, no-op, return and rotate-left instructions
//
// Notes on behaviour
// - or literal into working, update zero
// - load literal to working, flags untouched
// - load literal don't-care bits must be zero
// - or working with file, destination bit
// - store working into addressed file, no flags
// - move file to working or back
// - move file updates zero in both cases
// - rotate left through carry, destination bit
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "exec_defs.svh"
module or_move_rotate_execute
   import exec_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [`BUS_AW-1:0] busAddr,
   input wire logic [`BUS_DW-1:0] busWrData,
   input wire logic busWr,
   input wire logic busRd,
   output logic [`BUS_DW-1:0] busRdData,
   output logic globalInterruptEnable,
   output logic [`PC_W-1:0] progCounter,
   output logic instrDone
);
   localparam int SPW = $clog2(STACK_DEPTH);

   typedef struct packed {
      logic [`DATA_W-1:0] work;
      logic zero;
      logic carry;
      logic global_interrupt_enable;
      logic unsup;
      logic [`PC_W-1:0] pc;
      logic [SPW-1:0] sp;
      logic [STACK_DEPTH-1:0][`PC_W-1:0] stack;
      logic [`INSTR_W-1:0] lastInstr;
      logic [`BUS_DW-1:0] rdData;
      logic done;
   } exec_state_t;

   exec_state_t q;
   exec_state_t d;

   // stack pointer wraps, so depth must be a power of two
   generate
      if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
      begin : g_bad_depth
         $error("or_move_rotate_execute: STACK_DEPTH not power of two");
      end
   endgenerate

   logic [`INSTR_W-1:0] instr;
   logic execute;
   logic dest;
   logic [`FADDR_W-1:0] fAddr;
   logic [`DATA_W-1:0] lit;
   op_t op;
   logic [`DATA_W-1:0] fileVal;
   logic [`DATA_W-1:0] busFileVal;
   logic [`DATA_W-1:0] aluResult;
   logic aluZero;
   logic aluCarry;
   logic ramWrEn;
   logic [`FADDR_W-1:0] ramWrAddr;
   logic [`DATA_W-1:0] ramWrData;
   logic fileWrite;
   logic busFileSel;
   logic [`PC_W-1:0] topOfStack;

   // an instruction is issued by writing it to the instruction register
   assign instr = busWrData[`INSTR_W-1:0];
   assign execute = busWr && (busAddr == `REG_INSTR);
   assign dest = instr[`DEST_BIT];
   assign fAddr = instr[`FADDR_W-1:0];
   assign lit = instr[`DATA_W-1:0];
   assign busFileSel = busAddr[`FILE_SEL_BIT];
   assign topOfStack = q.stack[q.sp - `SP_STEP];

   // decode; unknown or out-of-set words fall to the unsupported case
   always_comb begin
      case (instr[`OPC_HI:`OPC_LO])
         `OPC_OR_LIT: op = OP_OR_LIT;
         `OPC_LOAD_LIT: op = OP_LOAD_LIT; // don't-cares must be zero
         `OPC_OR_FILE: op = OP_OR_FILE;
         `OPC_MOVE_FILE: op = OP_MOVE_FILE;
         `OPC_ROT_LEFT: op = OP_ROT_LEFT;
         `OPC_SYSTEM: begin
            if (instr[`STORE_BIT]) begin
               op = OP_STORE_W;
            end else if (instr == `INSTR_NOP) begin
               op = OP_NOP;
            end else if (instr == `INSTR_RET_INT) begin
               op = OP_RET_INT;
            end else begin
               op = OP_UNSUP;
            end
         end
         default: op = OP_UNSUP;
      endcase
   end

   exec_alu u_alu (
      .op(op),
      .workVal(q.work),
      .fileVal(fileVal),
      .literal(lit),
      .carryIn(q.carry),
      .result(aluResult),
      .zeroOut(aluZero),
      .carryOut(aluCarry)
   );

   // file writes: from an instruction, or from software on the file window
   always_comb begin
      case (op)
         OP_OR_FILE: fileWrite = dest;
         OP_STORE_W: fileWrite = 1'b1;
         OP_MOVE_FILE: fileWrite = dest;
         OP_ROT_LEFT: fileWrite = dest;
         default: fileWrite = 1'b0;
      endcase
      ramWrEn = (execute && fileWrite) || (busWr && busFileSel);
      ramWrAddr = execute ? fAddr : busAddr[`FADDR_W-1:0];
      ramWrData = execute ? aluResult : busWrData[`DATA_W-1:0];
   end

   file_reg_ram u_ram (
      .core_clk(core_clk),
      .wrEn(ramWrEn),
      .wrAddr(ramWrAddr),
      .wrData(ramWrData),
      .rdAddrA(fAddr),
      .rdDataA(fileVal),
      .rdAddrB(busAddr[`FADDR_W-1:0]),
      .rdDataB(busFileVal)
   );

   // next state: instruction effects, register writes, read data
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.rdData = '0;
      if (execute) begin
         d.lastInstr = instr;
         d.done = 1'b1;
         d.pc = q.pc + `PC_STEP;
         case (op)
            OP_OR_LIT: begin
               d.work = aluResult;
               d.zero = aluZero;
            end
            OP_LOAD_LIT: d.work = aluResult; // no flag touched
            OP_OR_FILE: begin
               if (!dest) begin
                  d.work = aluResult;
               end
               d.zero = aluZero;
            end
            OP_MOVE_FILE: begin
               if (!dest) begin
                  d.work = aluResult;
               end
               d.zero = aluZero; // either destination
            end
            OP_ROT_LEFT: begin
               if (!dest) begin
                  d.work = aluResult;
               end
               d.carry = aluCarry;
            end
            OP_RET_INT: begin
               d.pc = topOfStack;
               d.sp = q.sp - `SP_STEP;
               d.global_interrupt_enable = 1'b1;
            end
            OP_UNSUP: d.unsup = 1'b1;
            default: ; // no-op or store: only the counter moves here
         endcase
      end else if (busWr) begin
         case (busAddr)
            `REG_WORK: d.work = busWrData[`DATA_W-1:0];
            `REG_STATUS: begin
               d.zero = busWrData[`ST_ZERO];
               d.carry = busWrData[`ST_CARRY];
               d.global_interrupt_enable = busWrData[`ST_GIE];
               // write one to clear; never coincides with an execute
               d.unsup = q.unsup & ~busWrData[`ST_UNSUP];
            end
            `REG_PC: d.pc = busWrData[`PC_W-1:0];
            `REG_STACK: begin
               d.stack[q.sp] = busWrData[`PC_W-1:0];
               d.sp = q.sp + `SP_STEP;
            end
            default: ;
         endcase
      end
      // read data stand only in the cycle after the strobe
      if (busRd) begin
         if (busFileSel) begin
            d.rdData = {{(`BUS_DW-`DATA_W){1'b0}}, busFileVal};
         end else begin
            case (busAddr)
               `REG_INSTR: d.rdData = {{(`BUS_DW-`INSTR_W){1'b0}},
                                       q.lastInstr};
               `REG_WORK: d.rdData = {{(`BUS_DW-`DATA_W){1'b0}}, q.work};
               `REG_STATUS: d.rdData = {{(`BUS_DW-4){1'b0}}, q.unsup,
                                        q.global_interrupt_enable, q.carry, q.zero};
               `REG_PC: d.rdData = {{(`BUS_DW-`PC_W){1'b0}}, q.pc};
               `REG_STACK: d.rdData = {{(`BUS_DW-`PC_W){1'b0}},
                                       topOfStack};
               `REG_DEPTH: d.rdData = `BUS_DW'(q.sp);
               default: d.rdData = '0;
            endcase
         end
      end
   end

   // synchronous reset clears control state; stack contents need none
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         q.work <= `WORK_RST;
         q.zero <= 1'b0;
         q.carry <= 1'b0;
         q.global_interrupt_enable <= 1'b0;
         q.unsup <= 1'b0;
         q.pc <= `PC_RST;
         q.sp <= '0;
         q.lastInstr <= `INSTR_NOP;
         q.rdData <= '0;
         q.done <= 1'b0;
      end else begin
         q.work <= d.work;
         q.zero <= d.zero;
         q.carry <= d.carry;
         q.global_interrupt_enable <= d.global_interrupt_enable;
         q.unsup <= d.unsup;
         q.pc <= d.pc;
         q.sp <= d.sp;
         q.lastInstr <= d.lastInstr;
         q.rdData <= d.rdData;
         q.done <= d.done;
      end
      q.stack <= d.stack;
   end

   assign busRdData = q.rdData;
   assign globalInterruptEnable = q.global_interrupt_enable;
   assign progCounter = q.pc;
   assign instrDone = q.done;

   // checks on the execution results
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   AST_OR_LIT: assert property (
      execute && op == OP_OR_LIT |=>
         q.work == ($past(q.work) | $past(lit)) && q.zero == (q.work == '0))
      else $error("or literal result or zero flag wrong");

   AST_LOAD_LIT: assert property (
      execute && op == OP_LOAD_LIT |=>
         q.work == $past(lit) && $stable(q.zero) && $stable(q.carry))
      else $error("load literal wrong or flags changed");

   AST_DONT_CARE: assert property (
      execute && instr[`OPC_HI:`OPC_LO+2] == `OPC_LOAD_LIT >> 2
         && instr[`OPC_LO+1:`OPC_LO] != 2'b00 |=>
         q.unsup && $stable(q.work))
      else $error("nonzero don't-care bits not refused");

   AST_OR_FILE: assert property (
      execute && op == OP_OR_FILE |->
         (dest ? ramWrEn && ramWrData == (q.work | fileVal) : !ramWrEn)
         ##1 q.zero == ($past(ramWrData) == '0))
      else $error("or with file destination or zero wrong");

   AST_STORE_W: assert property (
      execute && op == OP_STORE_W |->
         ramWrEn && ramWrAddr == fAddr && ramWrData == q.work
         ##1 $stable(q.zero) && $stable(q.carry))
      else $error("store working wrong or flags changed");

   AST_MOVE_FILE: assert property (
      execute && op == OP_MOVE_FILE && !dest |=> q.work == $past(fileVal))
      else $error("move file to working wrong");

   AST_MOVE_ZERO: assert property (
      execute && op == OP_MOVE_FILE |=>
         q.zero == ($past(fileVal) == '0))
      else $error("move file zero flag wrong");

   AST_ROT_LEFT: assert property (
      execute && op == OP_ROT_LEFT && !dest |=>
         q.carry == $past(fileVal[`DATA_W-1]) &&
         q.work == {$past(fileVal[`DATA_W-2:0]), $past(q.carry)})
      else $error("rotate left result or carry wrong");

   AST_RET_INT: assert property (
      execute && op == OP_RET_INT |=>
         q.pc == $past(topOfStack) && q.global_interrupt_enable && $stable(q.zero)
         && $stable(q.carry) && q.sp == $past(q.sp) - `SP_STEP)
      else $error("return from interrupt wrong");

   AST_NOP: assert property (
      execute && op == OP_NOP |-> !ramWrEn ##1
         $stable(q.work) && $stable(q.zero) && $stable(q.carry)
         && $stable(q.global_interrupt_enable) && q.pc == $past(q.pc) + `PC_STEP)
      else $error("no-op changed state");
endmodule // or_move_rotate_execute

// file: logic/exec_defs.svh
// constants for the or/move/rotate execution block
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// widths
`define INSTR_W 14
`define DATA_W 8
`define PC_W 13
`define FADDR_W 7
`define BUS_AW 8
`define BUS_DW 16
`define FILE_WORDS 128

// register indices on the plain register port
`define REG_INSTR 8'h00
`define REG_WORK 8'h01
`define REG_STATUS 8'h02
`define REG_PC 8'h03
`define REG_STACK 8'h04
`define REG_DEPTH 8'h05
`define FILE_SEL_BIT 7

// status register bit positions
`define ST_ZERO 0
`define ST_CARRY 1
`define ST_GIE 2
`define ST_UNSUP 3

// instruction fields
`define OPC_HI 13
`define OPC_LO 8
`define DEST_BIT 7
`define STORE_BIT 7

// opcode patterns, bits 13:8; whole 14-bit words for no-op and return
`define OPC_OR_LIT 6'h38
`define OPC_LOAD_LIT 6'h30
`define OPC_OR_FILE 6'h04
`define OPC_MOVE_FILE 6'h08
`define OPC_ROT_LEFT 6'h0D
`define OPC_SYSTEM 6'h00
`define INSTR_NOP 14'h0000
`define INSTR_RET_INT 14'h0009

// reset values and counter steps
`define WORK_RST 8'h00
`define PC_RST 13'h0000
`define PC_STEP 13'h0001
`define SP_STEP 1'b1

`endif

// file: logic/exec_pkg.sv
// types shared by the execution block
package exec_pkg;
   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_OR_LIT = 4'h1,
      OP_LOAD_LIT = 4'h2,
      OP_OR_FILE = 4'h3,
      OP_STORE_W = 4'h4,
      OP_MOVE_FILE = 4'h5,
      OP_ROT_LEFT = 4'h6,
      OP_RET_INT = 4'h7,
      OP_UNSUP = 4'h8
   } op_t;
endpackage

// file: logic/exec_alu.sv
// result and flag logic for the supported operations
`timescale 1ns/10ps
`include "exec_defs.svh"
module exec_alu
   import exec_pkg::*;
(
   input wire op_t op,
   input wire logic [`DATA_W-1:0] workVal,
   input wire logic [`DATA_W-1:0] fileVal,
   input wire logic [`DATA_W-1:0] literal,
   input wire logic carryIn,
   output logic [`DATA_W-1:0] result,
   output logic zeroOut,
   output logic carryOut
);
   // one result path; the caller picks the destination
   always_comb begin
      carryOut = carryIn;
      case (op)
         OP_OR_LIT: result = workVal | literal;
         OP_LOAD_LIT: result = literal;
         OP_OR_FILE: result = workVal | fileVal;
         OP_STORE_W: result = workVal;
         OP_MOVE_FILE: result = fileVal;
         OP_ROT_LEFT: begin
            result = {fileVal[`DATA_W-2:0], carryIn};
            carryOut = fileVal[`DATA_W-1];
         end
         default: result = workVal;
      endcase
      zeroOut = (result == '0);
   end
endmodule // exec_alu

// file: logic/file_reg_ram.sv
// file register array, one write port and two read ports
`timescale 1ns/10ps
`include "exec_defs.svh"
module file_reg_ram #(
   parameter int WORDS = `FILE_WORDS,
   parameter int AW = `FADDR_W
) (
   input wire logic core_clk,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [`DATA_W-1:0] wrData,
   input wire logic [AW-1:0] rdAddrA,
   output logic [`DATA_W-1:0] rdDataA,
   input wire logic [AW-1:0] rdAddrB,
   output logic [`DATA_W-1:0] rdDataB
);
   typedef struct packed {
      logic [WORDS-1:0][`DATA_W-1:0] mem;
   } ram_state_t;

   ram_state_t q;
   ram_state_t d;

   generate
      if (WORDS > (1 << AW) || WORDS < 1) begin : g_bad_size
         $error("file_reg_ram: WORDS does not fit AW");
      end
   endgenerate

   // contents are data, not control, so no reset is needed
   always_comb begin
      d = q;
      if (wrEn) begin
         d.mem[wrAddr] = wrData;
      end
   end

   always_ff @(posedge core_clk) begin
      q <= d;
   end

   // asynchronous reads let an instruction finish in one cycle
   assign rdDataA = q.mem[rdAddrA];
   assign rdDataB = q.mem[rdAddrB];
endmodule // file_reg_ram

// file: bench/or_move_rotate_execute_tb.sv
// self-checking bench for the or/move/rotate execution block
`timescale 1ns/10ps
`include "exec_defs.svh"
module or_move_rotate_execute_tb;
   localparam int SD = 8;
   typedef struct packed {
      logic [15:0] d;
      logic [12:0] p;
      logic g;
   } note_t;

   logic core_clk = 1'h0;
   logic reset_n = 1'h0;
   logic [7:0] busAddr = 8'h00;
   logic [15:0] busWrData = 16'h0000;
   logic busWr = 1'h0;
   logic busRd = 1'h0;
   logic [15:0] busRdData;
   logic globalInterruptEnable;
   logic [12:0] progCounter;
   logic instrDone;
   int miscompares = 0;
   int comparisons = 0;
   integer seed = 32'h4924;
   note_t expQ[$];
   logic rdLag = 1'h0;
   logic doneLag = 1'h0;
   // reference state kept by the bench alone
   logic [7:0] wM = 8'h00;
   logic zM = 1'h0;
   logic cM = 1'h0;
   logic gM = 1'h0;
   logic uM = 1'h0;
   logic [12:0] pcM = 13'h0000;
   logic [7:0] fM [0:127];
   logic [12:0] stkM [0:SD-1];
   int spM = 0;

   or_move_rotate_execute #(.STACK_DEPTH(SD)) uut (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .busAddr(busAddr),
      .busWrData(busWrData),
      .busWr(busWr),
      .busRd(busRd),
      .busRdData(busRdData),
      .globalInterruptEnable(globalInterruptEnable),
      .progCounter(progCounter),
      .instrDone(instrDone)
   );

   // 250 MHz core clock
   always #2 core_clk = ~core_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // bus cycles: signals change right after an edge and hold one cycle
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      busWr <= 1'h1;
      busRd <= 1'h0;
      busAddr <= a;
      busWrData <= v;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      note_t n;
      n.d = e;
      n.p = pcM;
      n.g = gM;
      busRd <= 1'h1;
      busWr <= 1'h0;
      busAddr <= a;
      expQ.push_back(n);
      @(posedge core_clk);
   endtask

   task automatic idle();
      busRd <= 1'h0;
      busWr <= 1'h0;
      @(posedge core_clk);
   endtask

   // every readable register except the stack port against its reset value
   task automatic rst_reads();
      rd(`REG_WORK, 16'h0000);
      rd(`REG_STATUS, 16'h0000);
      rd(`REG_PC, 16'h0000);
      rd(`REG_DEPTH, 16'h0000);
      rd(`REG_INSTR, 16'h0000);
   endtask

   // issue one instruction and advance the reference state
   task automatic ex(input logic [13:0] i);
      logic [5:0] op;
      logic [7:0] fv;
      logic [7:0] r;
      logic dst;
      op = i[13:8];
      fv = fM[i[6:0]];
      r = 8'h00;
      dst = 1'h0;
      wr(`REG_INSTR, {2'h0, i});
      pcM = pcM + `PC_STEP;
      if (i == `INSTR_RET_INT) begin
         spM = (spM + SD - 1) % SD;
         pcM = stkM[spM];
         gM = 1'h1;
      end else if (i == `INSTR_NOP) begin
         r = 8'h00;
      end else if (op == `OPC_OR_LIT) begin
         wM = wM | i[7:0];
         zM = (wM == 8'h00);
      end else if (op == `OPC_LOAD_LIT) begin
         wM = i[7:0];
      end else if (op == `OPC_SYSTEM && i[`STORE_BIT]) begin
         fM[i[6:0]] = wM;
      end else if (op == `OPC_OR_FILE || op == `OPC_MOVE_FILE) begin
         r = (op == `OPC_OR_FILE) ? (wM | fv) : fv;
         zM = (r == 8'h00);
         dst = 1'h1;
      end else if (op == `OPC_ROT_LEFT) begin
         r = {fv[6:0], cM};
         cM = fv[7];
         dst = 1'h1;
      end else begin
         uM = 1'h1;
      end
      if (dst && i[`DEST_BIT]) begin
         fM[i[6:0]] = r;
      end else if (dst) begin
         wM = r;
      end
   endtask

   // answer watcher: oldest note against the read data and the outputs
   always @(posedge core_clk) begin
      note_t n;
      if (rdLag && expQ.size() == 0) begin
         miscompares++;
         $display("MISMATCH at %0t: read answer with no note", $time);
      end else if (rdLag) begin
         n = expQ.pop_front();
         check(busRdData, n.d);
         check({3'h0, progCounter}, {3'h0, n.p});
         check({15'h0000, globalInterruptEnable}, {15'h0000, n.g});
      end
      if (reset_n) begin
         check({15'h0000, instrDone}, {15'h0000, doneLag});
      end
      rdLag <= busRd;
      doneLag <= busWr && busAddr == `REG_INSTR;
   end

   // hang guard, several times the expected run length
   initial begin
      repeat (40000) @(posedge core_clk);
      miscompares++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      logic [31:0] rnd;
      logic [13:0] ins;
      logic [7:0] kv;
      int sel;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'h1;
      rst_reads();
      $display("test reset values done");
      // unmapped index and read-only depth ignore writes
      rnd = $random(seed);
      wr(8'h06, rnd[15:0]);
      wr(`REG_DEPTH, 16'h0005);
      rd(8'h06, 16'h0000);
      rd(8'h7F, 16'h0000);
      rd(`REG_DEPTH, 16'h0000);
      $display("test unmapped done");
      // file registers power up unknown, so fill them all; some zero
      for (int a = 0; a < 128; a++) begin
         rnd = $random(seed);
         fM[a] = rnd[2] ? rnd[10:3] : 8'h00;
         wr({1'h1, a[6:0]}, {8'h00, fM[a]});
      end
      rnd = $random(seed);
      wM = rnd[7:0];
      wr(`REG_WORK, {8'h00, wM});
      for (int it = 0; it < 400; it++) begin
         sel = $unsigned($random(seed)) % 9;
         rnd = $random(seed);
         kv = rnd[29] ? 8'h00 : rnd[7:0];
         case (sel)
            0: ins = {`OPC_OR_LIT, kv};
            1: ins = {`OPC_LOAD_LIT, kv};
            2: ins = {`OPC_OR_FILE, rnd[7:0]};
            3: ins = {`OPC_MOVE_FILE, rnd[7:0]};
            4: ins = {`OPC_ROT_LEFT, rnd[7:0]};
            5: ins = {`OPC_SYSTEM, 1'h1, rnd[6:0]};
            6: ins = `INSTR_NOP;
            7: ins = `INSTR_RET_INT;
            default: ins = {4'hC, rnd[9:8] | 2'h1, kv};
         endcase
         if (sel == 7) begin
            stkM[spM] = rnd[28:16];
            spM = (spM + 1) % SD;
            wr(`REG_STACK, {3'h0, rnd[28:16]});
            rd(`REG_STACK, {3'h0, rnd[28:16]});
         end
         if (rnd[31:30] == 2'h0) begin
            // status write also clears the sticky unsupported flag when its bit 3 is one
            {gM, cM, zM} = rnd[12:10];
            uM = rnd[13] ? 1'h0 : uM;
            wr(`REG_STATUS, {12'h000, rnd[13:10]});
         end
         ex(ins);
         rd(`REG_WORK, {8'h00, wM});
         rd(`REG_STATUS, {12'h000, uM, gM, cM, zM});
         rd(`REG_PC, {3'h0, pcM});
         rd({1'h1, ins[6:0]}, {8'h00, fM[ins[6:0]]});
         rd(`REG_DEPTH, spM[15:0]);
         rd(`REG_INSTR, {2'h0, ins});
      end
      $display("test random instruction stream done");
      // reset in mid-run: control state clears, file contents stay
      reset_n <= 1'h0;
      repeat (2) idle();
      reset_n <= 1'h1;
      {wM, zM, cM, gM, uM} = 12'h000;
      pcM = `PC_RST;
      spM = 0;
      rst_reads();
      $display("test mid-run reset done");
      repeat (3) idle();
      finish_test();
   end
endmodule // or_move_rotate_execute_tb
